// ==== core/bau_params.svh ====
// Constants for the target address unlock and oscillator ratio block.
`ifndef BAU_PARAMS_SVH
`define BAU_PARAMS_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define BAU_REG_TARGET_ADDR 8'h09
`define BAU_REG_OSC_RATIO 8'h0a
`define BAU_REG_UNLOCK 8'h0d
`define BAU_REG_SOFT_RESET 8'h0f
`define BAU_REG_OSC_CAL 8'h50

// ==========================================================================
// Key and unlock codes
// ==========================================================================
`define BAU_ADDR_KEY 8'had
`define BAU_UNLOCK_ALWAYS 16'h04ad
`define BAU_UNLOCK_INT 16'h44ad
`define BAU_UNLOCK_AUX 16'h84ad
`define BAU_UNLOCK_BOTH 16'hc4ad

// ==========================================================================
// Reset values and field positions
// ==========================================================================
`define BAU_ADDR_RESET 7'h64
`define BAU_UNLOCK_RESET 16'h0000
`define BAU_CAL_EN_BIT 5
`define BAU_SOFT_RESET_BIT 0
`define BAU_RATIO_W 12

// ==========================================================================
// Serial framing and ratio window
// ==========================================================================
`define BAU_BYTE_BITS 4'h8
`define BAU_BYTE_DEV 2'h0
`define BAU_BYTE_PTR 2'h1
`define BAU_BYTE_HI 2'h2
`define BAU_BYTE_LO 2'h3
`define BAU_SLOW_LAST 1'h1

`endif

// ==== core/bau_pkg.sv ====
// Types for the target address unlock and oscillator ratio block.
package bau_pkg;

   // ==========================================================================
   // Serial target state machine
   // ==========================================================================
   typedef enum logic [2:0] {
      BAU_IDLE = 3'h0,
      BAU_RX = 3'h1,
      BAU_ACK = 3'h2,
      BAU_TX = 3'h3,
      BAU_RACK = 3'h4
   } bau_state_t;

endpackage : bau_pkg

// ==== core/bau_osc_if.sv ====
// Interface between the register logic and the oscillator ratio counter.
`timescale 1ns/1ps
interface bau_osc_if #(parameter int RATIO_W = 12);
   logic cal_enable;
   logic soft_clear;
   logic [RATIO_W-1:0] ratio;

   // ==========================================================================
   // Register side and counter side
   // ==========================================================================
   modport ctl (output cal_enable, output soft_clear, input ratio);
   modport meas (input cal_enable, input soft_clear, output ratio);
endinterface : bau_osc_if

// ==== core/bau_osc_ratio.sv ====
// Counts fast oscillator edges over two slow oscillator periods.
`timescale 1ns/1ps
`include "bau_params.svh"
module bau_osc_ratio #(
   parameter int RATIO_W = `BAU_RATIO_W
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Oscillator pins
   input wire logic fast_osc_in,
   input wire logic slow_osc_in,
   // Register side
   bau_osc_if.meas osc
);

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   logic [1:0] osc_meta;
   logic [1:0] osc_sync;
   logic [1:0] osc_prev;
   logic fast_rise;
   logic slow_rise;
   logic armed;
   logic period_idx;
   logic [RATIO_W-1:0] cycle_cnt;

   // Both oscillators are foreign to core_clk, so each passes two flops first.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_meta <= 2'h0;
         osc_sync <= 2'h0;
         osc_prev <= 2'h0;
      end else begin
         osc_meta <= {slow_osc_in, fast_osc_in};
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   assign fast_rise = osc_sync[0] & ~osc_prev[0];
   assign slow_rise = osc_sync[1] & ~osc_prev[1];

   // ==========================================================================
   // Measurement window
   // ==========================================================================
   // The first slow edge only opens the window; each later second edge closes
   // it, stores the count and opens the next one at once.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         armed <= 1'b0;
         period_idx <= 1'b0;
         cycle_cnt <= '0;
         osc.ratio <= '0;
      end else if (osc.soft_clear) begin
         armed <= 1'b0;
         period_idx <= 1'b0;
         cycle_cnt <= '0;
         osc.ratio <= '0;
      end else if (!osc.cal_enable) begin
         armed <= 1'b0;
         period_idx <= 1'b0;
         cycle_cnt <= '0;
      end else if (slow_rise) begin
         if (!armed) begin
            armed <= 1'b1;
            period_idx <= 1'b0;
            cycle_cnt <= '0;
         end else if (period_idx == `BAU_SLOW_LAST) begin
            osc.ratio <= cycle_cnt;
            period_idx <= 1'b0;
            cycle_cnt <= '0;
         end else begin
            period_idx <= 1'b1;
         end
      end else if (armed && fast_rise && (cycle_cnt != {RATIO_W{1'b1}})) begin
         // Saturate rather than wrap so an over-long slow period reads as full scale.
         cycle_cnt <= cycle_cnt + 1'b1;
      end
   end

endmodule : bau_osc_ratio

// ==== core/bau_target.sv ====
// Serial target port with guarded address change and oscillator ratio readout.
`timescale 1ns/1ps
`include "bau_params.svh"
module bau_target #(
   parameter int RATIO_W = `BAU_RATIO_W
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Pin levels that gate the address unlock
   input wire logic int_pin_level,
   input wire logic aux_output_pin,
   // Oscillator pins
   input wire logic fast_osc_in,
   input wire logic slow_osc_in,
   // Device state
   output logic [6:0] target_address,
   output logic fast_osc_cal_enable,
   output logic soft_reset_out
);

   // ==========================================================================
   // Declarations
   // ==========================================================================
   bau_osc_if #(.RATIO_W(RATIO_W)) osc ();

   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic [1:0] bus_prev;
   logic scl_s;
   logic sda_s;
   logic int_s;
   logic aux_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   bau_pkg::bau_state_t state;
   logic [3:0] bit_cnt;
   logic [1:0] byte_cnt;
   logic [7:0] shift;
   logic [7:0] data_hi;
   logic [7:0] pointer;
   logic rw;
   logic [7:0] tx_sr;
   logic [15:0] tx_word;
   logic tx_lo;

   logic [15:0] unlock_code;
   logic soft_rst;
   logic byte_done;
   logic wr_stb;
   logic [15:0] wr_word;
   logic soft_hit;
   logic unlock_ok;
   logic addr_write_ok;
   logic [15:0] rd_word;

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   // Every pin is foreign to core_clk; the first stage feeds only the second.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 4'hf;
         pin_sync <= 4'hf;
      end else begin
         pin_meta <= {aux_output_pin, int_pin_level, sda_in, scl_in};
         pin_sync <= pin_meta;
      end
   end

   // Previous bus levels for edge and condition detection.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_prev <= 2'h3;
      end else begin
         bus_prev <= pin_sync[1:0];
      end
   end

   assign scl_s = pin_sync[0];
   assign sda_s = pin_sync[1];
   assign int_s = pin_sync[2];
   assign aux_s = pin_sync[3];
   assign scl_rise = scl_s & ~bus_prev[0];
   assign scl_fall = ~scl_s & bus_prev[0];
   assign start_det = scl_s & bus_prev[0] & bus_prev[1] & ~sda_s;
   assign stop_det = scl_s & bus_prev[0] & ~bus_prev[1] & sda_s;

   // ==========================================================================
   // Write decode
   // ==========================================================================
   // A register write completes when the low data byte has been shifted in.
   assign byte_done = (state == bau_pkg::BAU_RX) && scl_fall && (bit_cnt == `BAU_BYTE_BITS);
   assign wr_stb = byte_done && (byte_cnt == `BAU_BYTE_LO);
   assign wr_word = {data_hi, shift};
   assign soft_hit = wr_stb && (pointer == `BAU_REG_SOFT_RESET)
                     && wr_word[`BAU_SOFT_RESET_BIT];

   // Unlock permission from the loaded code and the pin levels.
   always_comb begin
      unique case (unlock_code)
         `BAU_UNLOCK_ALWAYS: unlock_ok = 1'b1;
         `BAU_UNLOCK_INT: unlock_ok = int_s;
         `BAU_UNLOCK_AUX: unlock_ok = aux_s;
         `BAU_UNLOCK_BOTH: unlock_ok = int_s & aux_s;
         default: unlock_ok = 1'b0;
      endcase
   end

   // The key byte must match as well as the unlock condition.
   assign addr_write_ok = wr_stb && (pointer == `BAU_REG_TARGET_ADDR)
                          && (data_hi == `BAU_ADDR_KEY) && unlock_ok;

   // ==========================================================================
   // Read mux
   // ==========================================================================
   // Reserved and write-only fields read as zero; unmapped offsets read zero.
   always_comb begin
      rd_word = 16'h0000;
      unique case (pointer)
         `BAU_REG_TARGET_ADDR: rd_word = {8'h00, target_address, 1'b0};
         `BAU_REG_OSC_RATIO: rd_word = {{(16 - RATIO_W){1'b0}}, osc.ratio};
         `BAU_REG_UNLOCK: rd_word = unlock_code;
         `BAU_REG_OSC_CAL: rd_word[`BAU_CAL_EN_BIT] = fast_osc_cal_enable;
         default: rd_word = 16'h0000;
      endcase
   end

   // ==========================================================================
   // Soft reset
   // ==========================================================================
   // The pulse lasts one cycle, resets address, unlock code, cal enable and ratio and idles the bus state machine, so the bit self-clears.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= soft_hit;
      end
   end

   assign soft_reset_out = soft_rst;
   assign osc.soft_clear = soft_rst;
   assign osc.cal_enable = fast_osc_cal_enable;

   // ==========================================================================
   // Registers
   // ==========================================================================
   // Target address only moves on a keyed, unlocked write or a soft reset.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         target_address <= `BAU_ADDR_RESET;
      end else if (soft_rst) begin
         target_address <= `BAU_ADDR_RESET;
      end else if (addr_write_ok) begin
         target_address <= wr_word[7:1];
      end
   end

   // Unlock code and calibration enable are plain read/write storage.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_code <= `BAU_UNLOCK_RESET;
         fast_osc_cal_enable <= 1'b0;
      end else if (soft_rst) begin
         unlock_code <= `BAU_UNLOCK_RESET;
         fast_osc_cal_enable <= 1'b0;
      end else if (wr_stb) begin
         if (pointer == `BAU_REG_UNLOCK) begin
            unlock_code <= wr_word;
         end
         if (pointer == `BAU_REG_OSC_CAL) begin
            fast_osc_cal_enable <= wr_word[`BAU_CAL_EN_BIT];
         end
      end
   end

   // ==========================================================================
   // Serial target state machine
   // ==========================================================================
   // The line is open drain: data is always low, only the enable moves.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Bits are sampled on clock rise and driven on clock fall, so the line is
   // stable while the host clock is high.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= bau_pkg::BAU_IDLE;
         bit_cnt <= 4'h0;
         byte_cnt <= `BAU_BYTE_DEV;
         shift <= 8'h00;
         data_hi <= 8'h00;
         pointer <= 8'h00;
         rw <= 1'b0;
         tx_sr <= 8'h00;
         tx_word <= 16'h0000;
         tx_lo <= 1'b0;
         sda_oe <= 1'b0;
      end else if (soft_rst || stop_det) begin
         state <= bau_pkg::BAU_IDLE;
         sda_oe <= 1'b0;
      end else if (start_det) begin
         state <= bau_pkg::BAU_RX;
         bit_cnt <= 4'h0;
         byte_cnt <= `BAU_BYTE_DEV;
         sda_oe <= 1'b0;
      end else begin
         unique case (state)
            bau_pkg::BAU_IDLE: begin
               sda_oe <= 1'b0;
            end
            bau_pkg::BAU_RX: begin
               if (scl_rise) begin
                  shift <= {shift[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  bit_cnt <= 4'h0;
                  if ((byte_cnt == `BAU_BYTE_DEV) && (shift[7:1] != target_address)) begin
                     state <= bau_pkg::BAU_IDLE;
                  end else if (soft_hit) begin
                     state <= bau_pkg::BAU_IDLE;
                  end else begin
                     state <= bau_pkg::BAU_ACK;
                     sda_oe <= 1'b1;
                     unique case (byte_cnt)
                        `BAU_BYTE_DEV: rw <= shift[0];
                        `BAU_BYTE_PTR: pointer <= shift;
                        `BAU_BYTE_HI: data_hi <= shift;
                        `BAU_BYTE_LO: pointer <= pointer + 8'h01;
                     endcase
                     // Further word pairs after a write keep auto-incrementing.
                     byte_cnt <= (byte_cnt == `BAU_BYTE_LO) ? `BAU_BYTE_HI
                                 : byte_cnt + 2'h1;
                  end
               end
            end
            bau_pkg::BAU_ACK: begin
               if (scl_fall) begin
                  if (rw) begin
                     state <= bau_pkg::BAU_TX;
                     tx_word <= rd_word;
                     tx_sr <= rd_word[15:8];
                     tx_lo <= 1'b0;
                     sda_oe <= ~rd_word[15];
                  end else begin
                     state <= bau_pkg::BAU_RX;
                     sda_oe <= 1'b0;
                  end
               end
            end
            bau_pkg::BAU_TX: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt == `BAU_BYTE_BITS) begin
                     state <= bau_pkg::BAU_RACK;
                     bit_cnt <= 4'h0;
                     sda_oe <= 1'b0;
                     if (tx_lo) begin
                        pointer <= pointer + 8'h01;
                     end
                  end else begin
                     tx_sr <= {tx_sr[6:0], 1'b0};
                     sda_oe <= ~tx_sr[6];
                  end
               end
            end
            bau_pkg::BAU_RACK: begin
               // A host that answers with a high level ends the read.
               if (scl_rise && sda_s) begin
                  state <= bau_pkg::BAU_IDLE;
               end else if (scl_fall) begin
                  state <= bau_pkg::BAU_TX;
                  if (tx_lo) begin
                     tx_word <= rd_word;
                     tx_sr <= rd_word[15:8];
                     sda_oe <= ~rd_word[15];
                  end else begin
                     tx_sr <= tx_word[7:0];
                     sda_oe <= ~tx_word[7];
                  end
                  tx_lo <= ~tx_lo;
               end
            end
            default: begin
               state <= bau_pkg::BAU_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Oscillator ratio counter
   // ==========================================================================
   bau_osc_ratio #(
      .RATIO_W(RATIO_W)
   ) u_osc_ratio (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .fast_osc_in(fast_osc_in),
      .slow_osc_in(slow_osc_in),
      .osc(osc.meas)
   );

endmodule : bau_target

// ==== bench/bau_host_model.sv ====
// Serial bus host and oscillator sources facing the target block.
`timescale 1ns/1ps
module bau_host_model (
   // Clock
   input wire logic core_clk,
   // Serial bus
   output logic scl,
   output logic sda_drv,
   input wire logic sda_wire,
   // Oscillators
   output logic fast_osc,
   output logic slow_osc
);
   // ==========
   // Oscillators
   // ==========
   // The fast source runs free and is not locked to core_clk, so edges land at any phase.
   initial begin
      fast_osc = 1'b0;
      forever #15.625 fast_osc = ~fast_osc;
   end

   // The slow source runs free at 32 kHz.
   initial begin
      slow_osc = 1'b0;
      forever #15625 slow_osc = ~slow_osc;
   end

   // ==========
   // Serial bus
   // ==========
   // Both lines idle high; a high on sda_drv means the host has released the line.
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // Eight core cycles per phase keeps every SCL level above the four cycle minimum.
   task automatic ph();
      repeat (8) @(posedge core_clk);
   endtask : ph

   // SDA moves only a full phase after SCL fell and is read late in the high phase.
   task automatic bit_io(input logic v, output logic s);
      sda_drv <= v;
      ph();
      scl <= 1'b1;
      ph();
      s = sda_wire;
      scl <= 1'b0;
      ph();
   endtask : bit_io

   task automatic start(input logic rep);
      if (rep) begin
         sda_drv <= 1'b1;
         ph();
         scl <= 1'b1;
         ph();
      end
      sda_drv <= 1'b0;
      ph();
      scl <= 1'b0;
      ph();
   endtask : start

   task automatic stop();
      sda_drv <= 1'b0;
      ph();
      scl <= 1'b1;
      ph();
      sda_drv <= 1'b1;
      ph();
   endtask : stop

   // One byte out and in at once; the ninth bit is the acknowledge.
   task automatic xfer(input logic [7:0] tx, input logic nack, output logic [7:0] rx,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(nack, s);
      ack = ~s;
   endtask : xfer

   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                     output logic [3:0] ak);
      logic [7:0] rx;
      start(1'b0);
      xfer({a, 1'b0}, 1'b1, rx, ak[3]);
      xfer(p, 1'b1, rx, ak[2]);
      xfer(d[15:8], 1'b1, rx, ak[1]);
      xfer(d[7:0], 1'b1, rx, ak[0]);
      stop();
   endtask : wr

   // The host acknowledges the high byte and refuses the low byte to end the read.
   task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d,
                     output logic [2:0] ak);
      logic s;
      start(1'b0);
      xfer({a, 1'b0}, 1'b1, d[15:8], ak[2]);
      xfer(p, 1'b1, d[15:8], ak[1]);
      start(1'b1);
      xfer({a, 1'b1}, 1'b1, d[15:8], ak[0]);
      xfer(8'hff, 1'b0, d[15:8], s);
      xfer(8'hff, 1'b1, d[7:0], s);
      stop();
   endtask : rd
endmodule : bau_host_model

// ==== bench/bau_target_sva.sv ====
// Concurrent checks on the ports of the target block.
`timescale 1ns/1ps
`include "bau_params.svh"
module bau_target_sva #(
   parameter int RATIO_W = `BAU_RATIO_W
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial bus pins
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Device state
   input wire logic [6:0] target_address,
   input wire logic fast_osc_cal_enable,
   input wire logic soft_reset_out
);
   // ==========
   // Properties
   // ==========
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   AST_RESET_STATE: assert property ($rose(rst_n) |-> target_address == `BAU_ADDR_RESET
      && !sda_oe && !fast_osc_cal_enable) else $error("state after reset is wrong");
   AST_SOFT_ONE_CYCLE: assert property (soft_reset_out |=> !soft_reset_out)
      else $error("soft reset pulse too long");
   AST_SOFT_CLEARS: assert property (soft_reset_out |-> ##[0:1]
      (target_address == `BAU_ADDR_RESET && !fast_osc_cal_enable))
      else $error("soft reset left state set");
   AST_SOFT_NO_ACK: assert property (soft_reset_out |=> !sda_oe [*8])
      else $error("soft reset write acknowledged");
   // Register updates follow a completed byte, so SCL is low unless a soft reset struck.
   AST_ADDR_SCL_LOW: assert property (!$stable(target_address) |-> !scl_in
      || soft_reset_out || $past(soft_reset_out)) else $error("address moved at bad time");
   AST_CAL_SCL_LOW: assert property ($changed(fast_osc_cal_enable) |-> !scl_in
      || soft_reset_out || $past(soft_reset_out)) else $error("cal enable moved at bad time");
   AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in && !sda_out)
      else $error("data line pulled while clock high");
   AST_OE_HELD_SCL_HIGH: assert property (scl_in [*4] |-> $stable(sda_oe))
      else $error("data line moved in clock high phase");

   COV_SOFT: cover property (soft_reset_out);
   COV_ADDR_MOVE: cover property ($changed(target_address) && !$past(soft_reset_out));
   COV_ACK: cover property ($rose(sda_oe));
endmodule : bau_target_sva

// ==== bench/bau_target_tb.sv ====
// Self-checking bench: register traffic to the target block through the host model.
`timescale 1ns/1ps
`include "bau_params.svh"
module bau_target_tb;
   // Two slow periods of 31.25 us over a fast period of 31.25 ns.
   localparam int RATIO_NOM = 2000;
   logic core_clk;
   logic rst_n;
   logic int_pin_level;
   logic aux_output_pin;
   logic scl;
   logic sda_drv;
   logic fast_osc;
   logic slow_osc;
   logic sda_out;
   logic sda_oe;
   wire sda_wire;
   logic [6:0] target_address;
   logic fast_osc_cal_enable;
   logic soft_reset_out;
   int fail_count = 0;
   int checked = 0;
   int pulses = 0;
   logic [6:0] adr;
   logic [6:0] na;
   logic [15:0] d;
   logic [3:0] ak;
   logic [2:0] rk;
   logic [15:0] codes [4] = '{`BAU_UNLOCK_ALWAYS, `BAU_UNLOCK_INT, `BAU_UNLOCK_AUX,
                              `BAU_UNLOCK_BOTH};

   // Open drain with pull-up: low only while someone pulls.
   assign sda_wire = sda_oe ? 1'b0 : sda_drv;

   // 125 MHz core clock.
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   bau_target u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .int_pin_level(int_pin_level),
      .aux_output_pin(aux_output_pin), .fast_osc_in(fast_osc), .slow_osc_in(slow_osc),
      .target_address(target_address), .fast_osc_cal_enable(fast_osc_cal_enable),
      .soft_reset_out(soft_reset_out)
   );

   bau_host_model u_host (
      .core_clk(core_clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire),
      .fast_osc(fast_osc), .slow_osc(slow_osc)
   );

   // Counts soft reset pulses so a missing or doubled one shows.
   always @(posedge core_clk) begin
      if (soft_reset_out === 1'b1) begin
         pulses <= pulses + 1;
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   // Watchdog sized above the roughly 60k cycles the sequence needs.
   initial begin
      repeat (90000) @(posedge core_clk);
      fail_count++;
      tally_and_finish();
   end

   // ==========
   // Main sequence
   // ==========
   initial begin
      rst_n = 1'b0;
      int_pin_level = 1'b0;
      aux_output_pin = 1'b0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      adr = `BAU_ADDR_RESET;
      chk("target_address", {9'h0, adr}, {9'h0, target_address});
      u_host.rd(adr, `BAU_REG_TARGET_ADDR, d, rk);
      chk("addr_reg", {8'h00, adr, 1'b0}, d);
      chk("read_acks", 16'h7, {13'h0, rk});
      u_host.rd(adr, `BAU_REG_UNLOCK, d, rk);
      chk("unlock_reset", `BAU_UNLOCK_RESET, d);
      u_host.rd(adr, `BAU_REG_OSC_RATIO, d, rk);
      chk("ratio_reset", 16'h0000, d);
      u_host.rd(adr, 8'h30, d, rk);
      chk("unmapped_read", 16'h0000, d);
      // A good key without an unlock code must be refused.
      u_host.wr(adr, `BAU_REG_TARGET_ADDR, {`BAU_ADDR_KEY, 7'h11, 1'b0}, ak);
      chk("locked_addr", {9'h0, adr}, {9'h0, target_address});
      u_host.wr(adr, `BAU_REG_UNLOCK, `BAU_UNLOCK_ALWAYS, ak);
      u_host.rd(adr, `BAU_REG_UNLOCK, d, rk);
      chk("unlock_rw", `BAU_UNLOCK_ALWAYS, d);
      u_host.wr(adr, `BAU_REG_TARGET_ADDR, {8'h12, 7'h11, 1'b0}, ak);
      chk("bad_key_addr", {9'h0, adr}, {9'h0, target_address});
      chk("bad_key_acks", 16'hf, {12'h0, ak});
      // Every unlock code against every pin combination.
      for (int c = 0; c < 4; c++) begin
         for (int p = 0; p < 4; p++) begin
            int_pin_level <= p[0];
            aux_output_pin <= p[1];
            na = 7'h10 + 7'(c * 4 + p);
            u_host.wr(adr, `BAU_REG_UNLOCK, codes[c], ak);
            u_host.wr(adr, `BAU_REG_TARGET_ADDR, {`BAU_ADDR_KEY, na, 1'b0}, ak);
            if ((!c[0] || p[0]) && (!c[1] || p[1])) begin
               adr = na;
            end
            chk("gated_addr", {9'h0, adr}, {9'h0, target_address});
         end
      end
      u_host.rd(`BAU_ADDR_RESET, `BAU_REG_TARGET_ADDR, d, rk);
      chk("stale_addr_acks", 16'h0, {13'h0, rk});
      u_host.rd(adr, `BAU_REG_TARGET_ADDR, d, rk);
      chk("new_addr_reg", {8'h00, adr, 1'b0}, d);
      // Oscillator ratio: a result needs up to three slow periods to appear.
      u_host.wr(adr, `BAU_REG_OSC_CAL, 16'h0001 << `BAU_CAL_EN_BIT, ak);
      chk("cal_enable", 16'h1, {15'h0, fast_osc_cal_enable});
      repeat (16000) @(posedge core_clk);
      u_host.rd(adr, `BAU_REG_OSC_RATIO, d, rk);
      chk("ratio_reserved", 16'h0, {12'h0, d[15:12]});
      chk("ratio_near_nom", 16'h1, {15'h0, (d[11:0] >= 12'(RATIO_NOM - 2))
          && (d[11:0] <= 12'(RATIO_NOM + 2))});
      // Soft reset: low byte refused, state back to reset values.
      u_host.wr(adr, `BAU_REG_SOFT_RESET, 16'h0001, ak);
      chk("soft_reset_acks", 16'he, {12'h0, ak});
      chk("soft_pulses", 16'h1, 16'(pulses));
      chk("addr_after_soft", {9'h0, `BAU_ADDR_RESET}, {9'h0, target_address});
      chk("cal_after_soft", 16'h0, {15'h0, fast_osc_cal_enable});
      u_host.rd(`BAU_ADDR_RESET, `BAU_REG_UNLOCK, d, rk);
      chk("unlock_after_soft", `BAU_UNLOCK_RESET, d);
      tally_and_finish();
   end
endmodule : bau_target_tb

bind bau_target bau_target_sva #(.RATIO_W(RATIO_W)) u_sva (
   .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .target_address(target_address),
   .fast_osc_cal_enable(fast_osc_cal_enable), .soft_reset_out(soft_reset_out)
);
